// [dma_chan_pkg.sv]
// Shared constants and types for the general DMA channel control block
package dma_chan_pkg;

    // ==========================================================
    // Register byte offsets
    localparam logic [7:0] OFF_MODE   = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_MASK   = 8'h08;
    localparam logic [7:0] OFF_SRC    = 8'h0c;
    localparam logic [7:0] OFF_DST    = 8'h10;
    localparam logic [7:0] OFF_FCODE  = 8'h14;
    localparam logic [7:0] OFF_COUNT  = 8'h18;
    localparam logic [7:0] OFF_BASE   = 8'h1c;
    localparam logic [7:0] OFF_PTR    = 8'h20;
    localparam logic [7:0] OFF_CMD    = 8'h24;
    localparam logic [7:0] OFF_DESC   = 8'h40;

    // ==========================================================
    // Channel mode register fields
    localparam int MB_RUN    = 0;
    localparam int MB_CHRST  = 1;
    localparam int MB_RREQ   = 2;
    localparam int MB_BM     = 3;
    localparam int MB_REQUEST_GENERATION_FIELD   = 5;
    localparam int MB_BW     = 7;
    localparam int MB_DSEL   = 9;
    localparam int MB_SADDR  = 10;
    localparam int MB_SYNBYP = 11;
    localparam logic [11:0] MODE_RST = 12'h000;

    // Buffer handling modes and request generation
    localparam logic [1:0] BM_SINGLE = 2'h0;
    localparam logic [1:0] BM_AUTO   = 2'h1;
    localparam logic [1:0] BM_CHAIN  = 2'h2;
    localparam logic [1:0] RG_MAX    = 2'h0;
    localparam logic [1:0] RG_LIMIT  = 2'h1;
    localparam logic [1:0] RG_BURST  = 2'h2;

    // Status bits, cleared by writing one
    localparam int SB_DONE  = 0;
    localparam int SB_BDONE = 1;
    localparam int SB_BERR  = 2;

    // Descriptor flag word bits
    localparam int DF_VALID = 15;
    localparam int DF_WRAP  = 13;
    localparam int DF_INT   = 12;
    localparam int DF_LAST  = 11;
    localparam int DF_CONT  = 9;
    localparam int DF_SERR  = 2;
    localparam int DF_DERR  = 1;
    localparam int DF_TERM  = 0;

    // ==========================================================
    // Limited-rate window and allotments, in clocks
    localparam int          WINDOW_CLKS = 1024;
    localparam logic [9:0]  ALLOT_12P5  = 10'd128;
    localparam logic [9:0]  ALLOT_25    = 10'd256;
    localparam logic [9:0]  ALLOT_50    = 10'd512;
    localparam logic [9:0]  ALLOT_75    = 10'd768;

    typedef enum logic [2:0] {
        ST_IDLE, ST_LOAD, ST_ARB, ST_RD, ST_WR, ST_CLOSE
    } state_e;

endpackage

// [general_dma_channel.sv]
// General DMA channel: register slave, descriptor ring, request and bus engine
// Contract
// - Terminate input closes buffer, flags it, event
// - Peripheral source: single-address ignores source pointer
// - Peripheral destination: single-address ignores destination pointer
// - Reinit command restores reset state, ring top
// - Running: address, code, count writes ignored
// - Request input ignored while run clear
// - Single mode: count zero or terminate clears run
// - Bus error clears run in every mode
// - Run cleared: finish operand, release, stop
// - Run set again: re-arbitrate and resume
// - Write-one clears status; interrupt then drops
// - Internal requests need run, ring needs enable
// - Maximum rate: one uninterrupted burst to end
// - Acknowledge asserted on every peripheral access
// - Limited rate caps share at four steps
// - Share over 1024-clock windows, no carry
// - Burst: request is level, held asserted
// - Burst: request withdrawn before grant, stop
// - Burst: keep cycling while request holds
// - After wrap descriptor continue at ring base
// - Chain clears valid, auto keeps it; the code also clears it in auto mode on terminate or bus error
// - Chain last descriptor exhausted: stop, event
// - Interrupt-flagged descriptor sets buffer-done status
module general_dma_channel (
    input  wire logic        ref_clk,
    input  wire logic        srst,
    input  wire logic [7:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    output logic             bus_req,
    input  wire logic        bus_grant,
    output logic             bus_cyc,
    output logic             bus_we,
    output logic      [31:0] bus_addr,
    output logic      [7:0]  bus_fc,
    output logic      [7:0]  bus_wdata,
    input  wire logic [7:0]  bus_rdata,
    input  wire logic        bus_ack,
    input  wire logic        bus_err,
    input  wire logic        transfer_request_n,
    output logic             transfer_acknowledge_n,
    input  wire logic        external_terminate_n,
    output logic             irq
);
    import dma_chan_pkg::*;

    logic [11:0] mode_q;
    logic [2:0]  status_q;
    logic [2:0]  mask_q;
    logic [31:0] src_q;
    logic [31:0] dst_q;
    logic [7:0]  fcode_q;
    logic [15:0] count_q;
    logic [1:0]  base_q;
    logic [1:0]  ptr_q;
    logic        loaded_q;
    logic [31:0] desc_q [0:15];
    state_e      state_q;
    logic        wait_q;
    logic [31:0] rdata_q;
    logic        req_q;
    logic        cyc_q;
    logic        we_q;
    logic [31:0] addr_q;
    logic [7:0]  data_q;
    logic        ackn_q;
    logic        irq_q;
    logic        cl_term_q;
    logic        cl_err_q;
    logic        cl_serr_q;
    logic        req_s1_q;
    logic        req_s2_q;
    logic [9:0]  win_q;
    logic [9:0]  used_q;

    // Decoded mode fields
    logic       run;
    logic [1:0] bm;
    logic [1:0] request_generation_field;
    logic       dev_src;
    logic       saddr;
    assign run     = mode_q[MB_RUN];
    assign bm      = mode_q[MB_BM +: 2];
    assign request_generation_field    = mode_q[MB_REQUEST_GENERATION_FIELD +: 2];
    assign dev_src = mode_q[MB_DSEL];
    assign saddr   = mode_q[MB_SADDR];

    // Slot index of a descriptor word
    function automatic logic [3:0] didx(input logic [1:0] p, input logic [1:0] w);
        return {p, w};
    endfunction

    // Clocks allowed per window for a bandwidth code
    function automatic logic [9:0] allot(input logic [1:0] bw);
        case (bw)
            2'h0:    return ALLOT_12P5;
            2'h1:    return ALLOT_25;
            2'h2:    return ALLOT_50;
            default: return ALLOT_75;
        endcase
    endfunction

    // ==========================================================
    // Avalon slave handshake
    logic wr_acc;
    logic reinit;
    assign wr_acc = avs_write & ~wait_q;
    assign reinit = wr_acc && avs_address == OFF_CMD && avs_writedata[0];

    // One wait cycle per access, then accept
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            wait_q <= 1'b1;
        end else if ((avs_read | avs_write) && wait_q) begin
            wait_q <= 1'b0;
        end else begin
            wait_q <= 1'b1;
        end
    end

    // Read mux, registered in the wait cycle
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (avs_address)
            OFF_MODE:   rd_mux = {20'h00000, mode_q};
            OFF_STATUS: rd_mux = {29'h0000_0000, status_q};
            OFF_MASK:   rd_mux = {29'h0000_0000, mask_q};
            OFF_SRC:    rd_mux = src_q;
            OFF_DST:    rd_mux = dst_q;
            OFF_FCODE:  rd_mux = {24'h000000, fcode_q};
            OFF_COUNT:  rd_mux = {16'h0000, count_q};
            OFF_BASE:   rd_mux = {30'h0000_0000, base_q};
            OFF_PTR:    rd_mux = {30'h0000_0000, ptr_q};
            default: begin
                if (avs_address[7:6] == OFF_DESC[7:6]) begin
                    rd_mux = desc_q[avs_address[5:2]];
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            rdata_q <= 32'h0000_0000;
        end else if (avs_read && wait_q) begin
            rdata_q <= rd_mux;
        end
    end

    // ==========================================================
    // Request input: two-flop path unless bypassed
    logic req_lvl;
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            req_s1_q <= 1'b0;
            req_s2_q <= 1'b0;
        end else begin
            req_s1_q <= ~transfer_request_n;
            req_s2_q <= req_s1_q;
        end
    end
    // Synchronised path costs two clocks of latency
    assign req_lvl = mode_q[MB_SYNBYP] ? ~transfer_request_n : req_s2_q;

    // Bandwidth window; unused share is simply lost
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            win_q  <= 10'd0;
            used_q <= 10'd0;
        end else begin
            win_q <= win_q + 10'd1;
            if (win_q == 10'(WINDOW_CLKS - 1)) begin
                used_q <= 10'd0;
            end else if (req_q && bus_grant && used_q != 10'h3ff) begin
                used_q <= used_q + 10'd1;
            end
        end
    end

    // Whether the channel wants the bus now
    logic want;
    always_comb begin
        case (request_generation_field)
            RG_MAX:   want = 1'b1;
            RG_LIMIT: want = used_q < allot(mode_q[MB_BW +: 2]);
            RG_BURST: want = req_lvl;
            default:  want = 1'b0;
        endcase
        want = want & run;
    end

    // ==========================================================
    // Close decisions, valid only in the close state
    logic       in_close;
    logic       ring;
    logic [31:0] flags;
    logic       ev_done;
    logic       ev_bdone;
    logic       run_clr;
    assign in_close = state_q == ST_CLOSE;
    assign ring     = bm != BM_SINGLE;
    assign flags    = desc_q[didx(ptr_q, 2'h0)];
    assign ev_done  = in_close && (!ring || cl_term_q
                      || (bm == BM_CHAIN && flags[DF_LAST] && !cl_err_q));
    assign ev_bdone = in_close && ring && flags[DF_INT] && !cl_err_q;
    assign run_clr  = in_close && (!ring || cl_err_q
                      || (bm == BM_CHAIN && (flags[DF_LAST] || cl_term_q)));

    // Operand finished this cycle
    logic op_end;
    assign op_end = bus_ack && !bus_err
                    && ((state_q == ST_RD && saddr) || state_q == ST_WR);

    // ==========================================================
    // Mode register; hardware stop beats a same-cycle write
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            mode_q <= MODE_RST;
        end else begin
            if (wr_acc && avs_address == OFF_MODE) begin
                mode_q <= avs_writedata[11:0];
            end
            if (run_clr || reinit) begin
                mode_q[MB_RUN] <= 1'b0;
            end
        end
    end

    // Status: events set, write-one clears, set wins
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            status_q <= 3'h0;
            mask_q   <= 3'h0;
            irq_q    <= 1'b0;
        end else begin
            if (wr_acc && avs_address == OFF_MASK) begin
                mask_q <= avs_writedata[2:0];
            end
            status_q <= (status_q
                         & ~((wr_acc && avs_address == OFF_STATUS)
                             ? avs_writedata[2:0] : 3'h0))
                        | {in_close && cl_err_q, ev_bdone, ev_done};
            irq_q <= |(status_q & mask_q);
        end
    end

    // Transfer registers: software only while stopped
    logic sw_ok;
    assign sw_ok = wr_acc && !run;
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            src_q   <= 32'h0000_0000;
            dst_q   <= 32'h0000_0000;
            fcode_q <= 8'h00;
            count_q <= 16'h0000;
            base_q  <= 2'h0;
        end else if (state_q == ST_LOAD) begin
            count_q <= desc_q[didx(ptr_q, 2'h1)][15:0];
            src_q   <= desc_q[didx(ptr_q, 2'h2)];
            dst_q   <= desc_q[didx(ptr_q, 2'h3)];
        end else if (op_end) begin
            count_q <= count_q - 16'h0001;
            // Only the memory side walks; the peripheral address stays
            if (dev_src) begin
                dst_q <= dst_q + 32'h0000_0001;
            end else begin
                src_q <= src_q + 32'h0000_0001;
            end
        end else if (sw_ok) begin
            case (avs_address)
                OFF_SRC:   src_q   <= avs_writedata;
                OFF_DST:   dst_q   <= avs_writedata;
                OFF_FCODE: fcode_q <= avs_writedata[7:0];
                OFF_COUNT: count_q <= avs_writedata[15:0];
                OFF_BASE:  base_q  <= avs_writedata[1:0];
                default:   ;
            endcase
        end
    end

    // Descriptor table; close write-back beats software
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            for (int i = 0; i < 16; i++) begin
                desc_q[i] <= 32'h0000_0000;
            end
        end else if (in_close && ring) begin
            // Chain, terminate and errors drop valid; auto keeps it
            if (bm == BM_CHAIN || cl_term_q || cl_err_q) begin
                desc_q[didx(ptr_q, 2'h0)][DF_VALID] <= 1'b0;
            end
            if (cl_term_q) begin
                desc_q[didx(ptr_q, 2'h0)][DF_TERM] <= 1'b1;
            end
            if (cl_err_q) begin
                desc_q[didx(ptr_q, 2'h0)][DF_SERR] <= cl_serr_q;
                desc_q[didx(ptr_q, 2'h0)][DF_DERR] <= !cl_serr_q;
            end
        end else if (wr_acc && avs_address[7:6] == OFF_DESC[7:6]) begin
            desc_q[avs_address[5:2]] <= avs_writedata;
        end
    end

    // ==========================================================
    // Channel engine
    logic       pa_rd;
    logic       pa_wr;
    logic       term_seen;
    assign pa_rd     = saddr || dev_src;
    assign pa_wr     = !dev_src;
    assign term_seen = !external_terminate_n;

    always_ff @(posedge ref_clk) begin
        if (srst || reinit) begin
            state_q   <= ST_IDLE;
            req_q     <= 1'b0;
            cyc_q     <= 1'b0;
            we_q      <= 1'b0;
            addr_q    <= 32'h0000_0000;
            data_q    <= 8'h00;
            ackn_q    <= 1'b1;
            loaded_q  <= 1'b0;
            ptr_q     <= srst ? 2'h0 : base_q;
            cl_term_q <= 1'b0;
            cl_err_q  <= 1'b0;
            cl_serr_q <= 1'b0;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    req_q <= 1'b0;
                    if (ring && !loaded_q) begin
                        // Ring work needs enable and a prepared entry
                        if (run && mode_q[MB_RREQ] && flags[DF_VALID]) begin
                            state_q <= ST_LOAD;
                        end
                    end else if (want && count_q != 16'h0000) begin
                        state_q <= ST_ARB;
                        req_q   <= 1'b1;
                    end
                end
                ST_LOAD: begin
                    loaded_q <= 1'b1;
                    state_q  <= ST_IDLE;
                end
                ST_ARB: begin
                    if (!want) begin
                        state_q <= ST_IDLE;
                        req_q   <= 1'b0;
                    end else if (bus_grant) begin
                        state_q <= ST_RD;
                        cyc_q   <= 1'b1;
                        we_q    <= saddr && dev_src;
                        // Single address uses only the memory pointer
                        addr_q  <= (saddr && dev_src) ? dst_q : src_q;
                        ackn_q  <= !pa_rd;
                    end
                end
                ST_RD, ST_WR: begin
                    if (bus_err) begin
                        cl_err_q  <= 1'b1;
                        cl_serr_q <= state_q == ST_RD && !(saddr && dev_src);
                        cl_term_q <= 1'b0;
                        state_q   <= ST_CLOSE;
                        cyc_q     <= 1'b0;
                        ackn_q    <= 1'b1;
                    end else if (bus_ack && state_q == ST_RD && !saddr) begin
                        data_q  <= bus_rdata;
                        state_q <= ST_WR;
                        we_q    <= 1'b1;
                        addr_q  <= dst_q;
                        ackn_q  <= !pa_wr;
                    end else if (op_end) begin
                        if (term_seen || count_q == 16'h0001) begin
                            cl_term_q <= term_seen;
                            cl_err_q  <= 1'b0;
                            state_q   <= ST_CLOSE;
                            cyc_q     <= 1'b0;
                            ackn_q    <= 1'b1;
                        end else if (want && bus_grant) begin
                            // Back-to-back while still owned and wanted
                            state_q <= ST_RD;
                            we_q    <= saddr && dev_src;
                            addr_q  <= (saddr && dev_src) ? dst_q + 32'h0000_0001
                                       : (dev_src ? src_q : src_q + 32'h0000_0001);
                            ackn_q  <= !pa_rd;
                        end else begin
                            // Suspend or preempt: release after the operand
                            state_q <= ST_IDLE;
                            req_q   <= 1'b0;
                            cyc_q   <= 1'b0;
                            we_q    <= 1'b0;
                            ackn_q  <= 1'b1;
                        end
                    end
                end
                ST_CLOSE: begin
                    req_q    <= 1'b0;
                    loaded_q <= 1'b0;
                    if (ring) begin
                        ptr_q <= flags[DF_WRAP] ? base_q : ptr_q + 2'h1;
                    end
                    state_q <= ST_IDLE;
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // ==========================================================
    // Outputs, all from flip-flops
    assign avs_readdata           = rdata_q;
    assign avs_waitrequest        = wait_q;
    assign bus_req                = req_q;
    assign bus_cyc                = cyc_q;
    assign bus_we                 = we_q;
    assign bus_addr               = addr_q;
    assign bus_fc                 = fcode_q;
    assign bus_wdata              = data_q;
    assign transfer_acknowledge_n = ackn_q;
    assign irq                    = irq_q;

    // ==========================================================
    // Checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);

    run_after_reset_a: assert property ($fell(srst) |-> !run)
        else $error("run set after reset");
    req_ignored_a: assert property (state_q == ST_IDLE && !run |=> state_q != ST_ARB)
        else $error("request taken while stopped");
    write_protect_a: assert property (wr_acc && avs_address == OFF_COUNT && run
        && state_q == ST_IDLE |=> count_q == $past(count_q))
        else $error("count altered while running");
    single_stop_a: assert property (in_close && bm == BM_SINGLE |=> !run)
        else $error("single mode did not stop");
    error_stop_a: assert property (state_q == ST_RD && bus_err |=> ##1 !run)
        else $error("bus error left channel running");
    suspend_a: assert property (!run && state_q == ST_IDLE |=> !bus_cyc ##1 !bus_cyc)
        else $error("cycle started while suspended");
    irq_drop_a: assert property ((status_q & mask_q) == 3'h0 |=> !irq)
        else $error("interrupt held after clear");
    ack_cycle_a: assert property (!transfer_acknowledge_n |-> bus_cyc)
        else $error("acknowledge outside a bus cycle");
    share_cap_a: assert property (request_generation_field == RG_LIMIT && state_q == ST_IDLE
        && used_q >= allot(mode_q[MB_BW +: 2]) |=> state_q != ST_ARB)
        else $error("share exceeded");
    burst_drop_a: assert property (state_q == ST_ARB && request_generation_field == RG_BURST && !req_lvl
        |=> state_q == ST_IDLE && !bus_req)
        else $error("bus still requested after withdrawal");
    term_done_a: assert property (state_q == ST_CLOSE && cl_term_q |=> status_q[SB_DONE])
        else $error("terminate event missing");

    normal_close_c: cover property (in_close && !cl_term_q && !cl_err_q);
    term_close_c: cover property (in_close && cl_term_q && ring);
    burst_run_c: cover property (request_generation_field == RG_BURST && op_end ##1 state_q == ST_RD);

endmodule // general_dma_channel

// [periph_model.sv]
// Peripheral pins and system bus responder facing the DMA channel
module periph_model (
    input  wire logic       ref_clk,
    input  wire logic       bus_req,
    input  wire logic       bus_cyc,
    input  wire logic       req_on,
    input  wire logic       term_on,
    input  wire logic       err_on,
    output logic            transfer_request_n = 1'b1,
    output logic            external_terminate_n = 1'b1,
    output logic            bus_grant = 1'b0,
    output logic            bus_ack = 1'b0,
    output logic            bus_err = 1'b0,
    output logic      [7:0] bus_rdata = 8'h00
);
    timeunit 1ns;
    timeprecision 1ns;
    logic wait_q = 1'b0;
    // ==========================================================
    // Grant follows request; one wait state so acks never come free
    always @(posedge ref_clk) begin
        bus_grant <= bus_req;
        transfer_request_n <= !req_on;
        external_terminate_n <= !(term_on && bus_cyc);
        wait_q <= bus_cyc && !wait_q && !bus_ack && !bus_err;
        bus_ack <= wait_q && !err_on;
        bus_err <= wait_q && err_on;
        bus_rdata <= bus_cyc ? 8'h5a : ~bus_rdata; // Released lines toggle
    end
endmodule // periph_model

// [general_dma_channel_tb.sv]
// Self-checking bench for the general DMA channel
module general_dma_channel_tb;
    import dma_chan_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic        ref_clk = 0, srst = 1, avs_read = 0, avs_write = 0;
    logic [7:0]  avs_address = 8'h00, bus_fc, bus_wdata, bus_rdata;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, bus_addr, q;
    logic        avs_waitrequest, bus_req, bus_grant, bus_cyc, bus_we, bus_ack, bus_err, irq;
    logic        transfer_request_n, transfer_acknowledge_n, external_terminate_n;
    logic        req_on = 0, term_on = 0, err_on = 0;
    int          fail_count = 0, tests_run = 0, ack_cnt = 0;
    typedef struct { logic [7:0] wa; logic [31:0] wd; logic [7:0] ra; logic [31:0] ex; } row_s;
    // Write one place, read it back; the CMD row reads PTR instead; last rows hit reinit and a hole
    row_s rows [7] = '{'{OFF_MASK, 32'h7, OFF_MASK, 32'h7}, '{OFF_SRC, 32'h100, OFF_SRC, 32'h100},
        '{OFF_DST, 32'h200, OFF_DST, 32'h200}, '{OFF_COUNT, 32'h12345, OFF_COUNT, 32'h2345},
        '{OFF_BASE, 32'h1, OFF_BASE, 32'h1}, '{OFF_CMD, 32'h1, OFF_PTR, 32'h1},
        '{8'h30, 32'hff, 8'h30, 32'h0}};
    general_dma_channel dut (.ref_clk, .srst, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_readdata, .avs_waitrequest, .bus_req, .bus_grant, .bus_cyc,
        .bus_we, .bus_addr, .bus_fc, .bus_wdata, .bus_rdata, .bus_ack, .bus_err,
        .transfer_request_n, .transfer_acknowledge_n, .external_terminate_n, .irq);
    periph_model peer (.ref_clk, .bus_req, .bus_cyc, .req_on, .term_on, .err_on,
        .transfer_request_n, .external_terminate_n, .bus_grant, .bus_ack, .bus_err, .bus_rdata);
    always #25 ref_clk = ~ref_clk;
    // Peripheral-side operands completed
    // Peripheral write: fixed device address, code and data carried
    always @(posedge ref_clk) begin
        if (bus_ack && !transfer_acknowledge_n) begin
            ack_cnt++;
            chk(bus_addr, 32'h200);
            chk(32'({bus_we, bus_fc, bus_wdata}), 32'h0001_115a);
        end
    end
    // ==========================================================
    // Tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One Avalon access; holds until waitrequest is sampled low
    task automatic av(input logic wr, input logic [7:0] a, input logic [31:0] d);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        do begin
            @(posedge ref_clk);
        end while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge ref_clk);
    endtask
    // Poll the mode register until the channel stops; only the watchdog ends a hang
    task automatic wait_stop();
        do begin
            av(1'b0, OFF_MODE, 32'h0);
        end while (q[MB_RUN] !== 1'b0);
    endtask
    task automatic results();
        $display("comparisons %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // ==========================================================
    // Sequence
    initial begin
        repeat (6) @(posedge ref_clk);
        srst <= 1'b0;
        req_on <= 1'b1;
        @(posedge ref_clk);
        av(1'b0, OFF_MODE, 32'h0);
        chk(q, 32'h0);
        av(1'b1, OFF_MODE, 32'h42);
        repeat (10) @(posedge ref_clk);
        chk(32'(bus_req), 32'h0);
        foreach (rows[i]) begin
            av(1'b1, rows[i].wa, rows[i].wd);
            av(1'b0, rows[i].ra, 32'h0);
            chk(q, rows[i].ex);
        end
        av(1'b1, OFF_COUNT, 32'h3);
        av(1'b1, OFF_FCODE, 32'h11);
        av(1'b1, OFF_MODE, 32'h41);
        av(1'b1, OFF_FCODE, 32'h22);
        wait_stop();
        av(1'b0, OFF_FCODE, 32'h0);
        chk(q, 32'h11);
        av(1'b0, OFF_COUNT, 32'h0);
        chk(q, 32'h0);
        chk(ack_cnt, 32'h3);
        req_on <= 1'b0;
        av(1'b1, OFF_COUNT, 32'h2);
        av(1'b1, OFF_MODE, 32'h41);
        repeat (20) @(posedge ref_clk);
        chk(32'(bus_req), 32'h0);
        av(1'b1, OFF_COUNT, 32'h7);
        // One-clock request: seen in arbitration, then withdrawn
        req_on <= 1'b1;
        @(posedge ref_clk);
        req_on <= 1'b0;
        repeat (10) @(posedge ref_clk);
        chk(32'(bus_req), 32'h0);
        chk(ack_cnt, 32'h3);
        req_on <= 1'b1;
        wait_stop();
        chk(ack_cnt, 32'h5);
        av(1'b1, OFF_STATUS, 32'h7);
        av(1'b1, OFF_COUNT, 32'h2);
        err_on <= 1'b1;
        av(1'b1, OFF_MODE, 32'h01);
        wait_stop();
        av(1'b0, OFF_STATUS, 32'h0);
        chk(32'(q[SB_BERR]), 32'h1);
        chk(32'(irq), 32'h1);
        err_on <= 1'b0;
        av(1'b1, OFF_STATUS, 32'h7);
        @(posedge ref_clk);
        chk(32'(irq), 32'h0);
        term_on <= 1'b1;
        av(1'b1, OFF_COUNT, 32'h5);
        av(1'b1, OFF_MODE, 32'h01);
        wait_stop();
        av(1'b0, OFF_STATUS, 32'h0);
        chk(32'(q[SB_DONE]), 32'h1);
        av(1'b0, OFF_COUNT, 32'h0);
        chk(q, 32'h4);
        // Chain mode: one last, wrapping, interrupt-flagged entry at ring slot 1
        term_on <= 1'b0;
        av(1'b1, OFF_STATUS, 32'h7);
        av(1'b1, 8'h50, 32'h0000_b800);
        av(1'b1, 8'h54, 32'h2);
        av(1'b1, 8'h58, 32'h300);
        av(1'b1, 8'h5c, 32'h200);
        av(1'b1, OFF_MODE, 32'h15);
        wait_stop();
        av(1'b0, OFF_STATUS, 32'h0);
        chk(q, 32'h3);
        av(1'b0, 8'h50, 32'h0);
        chk(q, 32'h3800);
        av(1'b0, OFF_PTR, 32'h0);
        chk(q, 32'h1);
        chk(ack_cnt, 32'h8);
        results();
    end
    // Watchdog well beyond the expected few hundred cycles
    initial begin
        repeat (20000) @(posedge ref_clk);
        fail_count++;
        results();
    end
endmodule // general_dma_channel_tb
